// ### testbench/spe_link_asserts.sv
// Checker watching the serial link between the port end and the peer end.
module spe_link_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic [1:0] cs_n
);
  logic       sck_q;
  logic [3:0] rise_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Keeps last cycle's clock level so rises can be found.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sck_q <= 1'b0;
    else sck_q <= sck_o;
  end
  // Counts clock rises inside a frame and clears while both selects are high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rise_q <= 4'h0;
    else if (&cs_n) rise_q <= 4'h0;
    else if (sck_o && !sck_q) rise_q <= rise_q + 4'h1;
  end
  sequence s_frame_start;
    $fell(&cs_n);
  endsequence
  sequence s_frame_end;
    $rose(&cs_n);
  endsequence
  a_select_exclusive: assert property (cs_n != 2'b00)
    else $error("both selects low");
  a_frame_pulses: assert property (s_frame_end |->
    (5'(rise_q) + 5'(sck_o & ~sck_q)) inside {5'h08, 5'h09}) else $error("pulse count");
  a_select_holds: assert property (s_frame_start |-> ##1 $stable(cs_n) [*8])
    else $error("short frame");
  a_clock_driven: assert property (!(&cs_n) |-> sck_oe)
    else $error("clock not driven");
  a_gap_after: assert property (s_frame_end |=> &cs_n)
    else $error("no gap");
  a_data_settled: assert property ($changed(mosi) && !(&cs_n) |-> !(sck_o && !sck_q))
    else $error("data moved on a sampling edge");
endmodule

// ### testbench/spe_port_errata_behaviour_tb.sv
// Bench joining the port end and the peer end over one serial link.
`include "spe_map.svh"
module spe_port_errata_behaviour_tb import spe_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, irq, rx_valid, gotv = 0, sq = 0, csq = 1;
  logic        sck_in = 0, cs_in_n = 1, cp, nc, cs, mk;
  logic [7:0]  d0, d1;
  spe_char_t   reply = '0, rx_char, got = '0, tx;
  int          errors = 0, cmp_count = 0, pulses = 0, base, k;
  spe_link_if link ();
  spe_port u_spe_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link.port), .sck_in(sck_in), .cs_in_n(cs_in_n));
  spe_peer u_spe_peer (.pclk(pclk), .presetn(presetn), .link(link.peer), .reply(reply),
    .rx_char(rx_char), .rx_valid(rx_valid));
  spe_link_asserts u_chk (.pclk(pclk), .presetn(presetn), .sck_o(link.sck_o),
    .sck_oe(link.sck_oe), .mosi(link.mosi), .miso(link.miso), .cs_n(link.cs_n));
  // Clock at 40 MHz.
  always #12.5 pclk = ~pclk;
  // Counts link clock rises in a frame and keeps the byte the peer took.
  always @(posedge pclk) begin
    sq <= link.sck_o;
    csq <= &link.cs_n;
    if (!(csq && &link.cs_n) && link.sck_o && !sq) pulses <= pulses + 1;
    if (rx_valid) begin
      got <= rx_char;
      gotv <= 1'b1;
    end
  end
  function automatic int npulse(logic p, logic h, logic [7:0] a, logic [7:0] b);
    return (p && !h && ((a == 8'h01) != (b == 8'h01))) ? 9 : 8;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    if (n >= 40) begin
      errors++;
      summarize();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wcs(input logic idle);
    int n = 0;
    while ((&link.cs_n) !== idle && n++ < 4000) @(posedge pclk);
    if (n > 4000) begin
      errors++;
      summarize();
    end
  endtask
  // Master frames with random settings, then the slave sequence.
  initial begin
    void'($urandom(30));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `SPE_STAT_OFF, '0);
    chk(rd, 32'h0000_0002);
    apb(0, 12'h0FC, '0);
    chk(rd, 32'h0000_0000);
    chk(pslverr, 1'b0);
    for (int i = 0; i < 6; i++) begin
      cp = (i < 2) | 1'($urandom);
      nc = (i >= 2) & 1'($urandom);
      // Test 0 splits the dividers; test 1 keeps every divider at one.
      d0 = (i < 2) ? 8'h01 : 8'($urandom_range(3, 1));
      d1 = (i == 0) ? 8'h02 : (i == 1) ? 8'h01 : 8'($urandom_range(3, 1));
      {cs, mk, tx} = 10'($urandom);
      reply <= spe_char_t'($urandom);
      apb(1, `SPE_MODE_OFF, {8'h00, d1, d0, 3'h0, cs, 1'b0, nc, cp, 1'b1});
      apb(1, `SPE_MASK_OFF, {31'h0, mk});
      apb(1, `SPE_CTRL_OFF, 32'h1);
      base = pulses;
      gotv = 0;
      apb(1, `SPE_TXD_OFF, {24'h0, tx});
      wcs(0);
      wcs(1);
      k = 0;
      while (!gotv && k++ < 200) @(posedge pclk);
      chk(gotv, 1'b1);
      chk(pulses - base, npulse(cp, nc, d0, d1));
      // Master mode has no receive path: flag, interrupt and holding register stay clear.
      apb(0, `SPE_STAT_OFF, '0);
      chk(rd[0], 1'b0);
      chk(irq, 1'b0);
      apb(0, `SPE_RXD_OFF, '0);
      chk(rd[7:0], 8'h00);
      if (npulse(cp, nc, d0, d1) == 8) begin
        chk({gotv, got}, {1'b1, tx});
      end
      apb(0, `SPE_STAT_OFF, '0);
      chk({irq, rd[0]}, 2'b00);
      $display("master test %0d done", i);
    end
    apb(1, `SPE_CTRL_OFF, 32'h4);
    apb(0, `SPE_STAT_OFF, '0);
    chk(rd[2], 1'b0);
    apb(1, `SPE_CTRL_OFF, 32'h2);
    apb(1, `SPE_MODE_OFF, '0);
    apb(1, `SPE_CTRL_OFF, 32'h1);
    apb(1, `SPE_MASK_OFF, 32'h1);
    // Seven bits in, then the polarity flip completes a false character.
    cs_in_n <= 1'b0;
    repeat (14) begin
      repeat (4) @(posedge pclk);
      sck_in <= ~sck_in;
    end
    repeat (4) @(posedge pclk);
    apb(1, `SPE_MODE_OFF, 32'h2);
    cs_in_n <= 1'b1;
    apb(0, `SPE_STAT_OFF, '0);
    chk({irq, rd[0]}, 2'b11);
    apb(1, `SPE_MODE_OFF, '0);
    apb(0, `SPE_RXD_OFF, '0);
    apb(0, `SPE_STAT_OFF, '0);
    chk({irq, rd[2], rd[0]}, 3'b010);
    // One clean slave character at the bench link clock of 200 ns.
    cs_in_n <= 1'b0;
    repeat (16) begin
      repeat (4) @(posedge pclk);
      sck_in <= ~sck_in;
    end
    repeat (4) @(posedge pclk);
    cs_in_n <= 1'b1;
    k = 0;
    do apb(0, `SPE_STAT_OFF, '0); while (!rd[0] && k++ < 8);
    chk(rd[0], 1'b1);
    chk(irq, 1'b1);
    chk(rd[31:3], 29'h0);
    apb(1, `SPE_CTRL_OFF, 32'h4);
    apb(0, `SPE_STAT_OFF, '0);
    chk(rd[2], 1'b1);
    apb(0, `SPE_RXD_OFF, '0);
    chk(rd[7:0], {8{reply[7]}});
    apb(1, `SPE_CTRL_OFF, 32'h2);
    apb(0, `SPE_STAT_OFF, '0);
    chk({irq, rd[2], rd[0]}, 3'b000);
    apb(0, `SPE_MODE_OFF, '0);
    chk(rd, `SPE_MODE_RST);
    $display("slave test done");
    summarize();
  end
endmodule

// ### verilog/spe_link_if.sv
// Serial link between the port and its external partner.
interface spe_link_if;
  logic sck_o;
  logic sck_oe;
  logic mosi;
  logic miso;
  logic [1:0] cs_n;
  modport port (output sck_o, output sck_oe, output mosi, output cs_n, input miso);
  modport peer (input sck_o, input sck_oe, input mosi, input cs_n, output miso);
endinterface

// ### verilog/spe_map.svh
// Offsets, field positions, reset values and timing periods in ns of the serial port.
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH
`define SPE_CTRL_OFF     12'h000
`define SPE_MODE_OFF     12'h004
`define SPE_STAT_OFF     12'h008
`define SPE_MASK_OFF     12'h00C
`define SPE_TXD_OFF      12'h010
`define SPE_RXD_OFF      12'h014
`define SPE_CTRL_EN      0
`define SPE_CTRL_SWRST   1
`define SPE_CTRL_DIS     2
`define SPE_MODE_MASTER  0
`define SPE_MODE_CLOCK_POLARITY    1
`define SPE_MODE_CLOCK_PHASE_SELECT   2
`define SPE_MODE_CLOCK_SOURCE_DIVIDE_SELECT    3
`define SPE_MODE_CS      4
`define SPE_MODE_DIV0    8
`define SPE_MODE_DIV1    16
`define SPE_ST_RXRDY     0
`define SPE_ST_TXEMPTY   1
`define SPE_ST_ACTIVE    2
`define SPE_MODE_RST     32'h0000_0000
`define SPE_LINK_PERIOD_NS 200
`define SPE_CLK_PERIOD_NS  25
`endif

// ### verilog/spe_peer.sv
// External partner end: a simple serial slave that returns a fixed reply byte.
module spe_peer
  import spe_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  spe_link_if.peer       link,
  input  wire spe_char_t reply,
  output spe_char_t      rx_char,
  output logic           rx_valid
);
  logic [2:0] s;
  logic       sck_prev_q, miso_q;
  logic [2:0] bit_q;
  spe_char_t  sh_q;

  spe_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({link.sck_o, link.cs_n[0] & link.cs_n[1], link.mosi}),
    .dout    (s)
  );

  // Samples data on each rising link clock edge while selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b0;
      bit_q      <= '0;
      sh_q       <= '0;
      rx_char    <= '0;
      rx_valid   <= 1'b0;
      miso_q     <= 1'b0;
    end else begin
      sck_prev_q <= s[2];
      rx_valid   <= 1'b0;
      miso_q     <= reply[3'd7 - bit_q];
      if (s[1]) begin
        bit_q <= '0;
      end else if (s[2] && !sck_prev_q) begin
        sh_q  <= {sh_q[6:0], s[0]};
        bit_q <= bit_q + 3'd1;
        if (bit_q == 3'd7) begin
          rx_char  <= {sh_q[6:0], s[0]};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  assign link.miso = miso_q;
endmodule

// ### verilog/spe_pkg.sv
// Types of the serial port; only the character type is shared by both ends.
package spe_pkg;
  typedef enum logic [1:0] {SPE_IDLE, SPE_LEAD, SPE_TRAIL, SPE_GAP} spe_state_t;
  typedef logic [7:0] spe_char_t;
endpackage

// ### verilog/spe_port.sv
// Serial port end: APB registers, master clock generation and slave receiver.
// Overview of operation
// - Slave mode never reports transmit underrun.
// - Software keeps divide-select option cleared.
// - Mixed dividers, idle-high phase zero: extra pulse.
// - Software uses divider one on all selects.
// - Slave polarity change may raise false receive flag.
// - Software toggles polarity, reads holding register.
// - Disable request ignored in slave mode.
// - Software reads last character, then resets.
`include "spe_map.svh"
module spe_port
  import spe_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  spe_link_if.port         link,
  input  wire logic        sck_in,
  input  wire logic        cs_in_n
);
  logic [31:0] mode_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic        en_q;
  spe_char_t   rx_hold_q, sh_q;
  logic [2:0]  bit_q;
  logic [7:0]  cnt_q;
  logic        cs_sel_q;
  logic        sck_q, sck_oe_q, mosi_q;
  logic [1:0]  cs_q;
  logic        extra_q;
  spe_state_t  st_q;
  spe_char_t   sh_q_m;
  logic [2:0]  bit_m_q;
  logic [2:0]  pins_s;
  logic        sck_prev_q, pol_prev_q;
  logic        wr, rd, swrst, rx_load, glitch;
  logic        master, clock_polarity, clock_phase_select;
  logic [7:0]  div;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign master  = mode_q[`SPE_MODE_MASTER];
  assign clock_polarity    = mode_q[`SPE_MODE_CLOCK_POLARITY];
  assign clock_phase_select   = mode_q[`SPE_MODE_CLOCK_PHASE_SELECT];
  assign div     = cs_sel_q ? mode_q[`SPE_MODE_DIV1 +: 8] : mode_q[`SPE_MODE_DIV0 +: 8];
  assign swrst   = wr && paddr == `SPE_CTRL_OFF && pwdata[`SPE_CTRL_SWRST];

  spe_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({sck_in, cs_in_n, link.miso}),
    .dout    (pins_s)
  );

  // Control and mode registers; a software reset restores defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `SPE_MODE_RST;
      mask_q <= '0;
      en_q   <= 1'b0;
    end else if (swrst) begin
      mode_q <= `SPE_MODE_RST;
      mask_q <= '0;
      en_q   <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `SPE_CTRL_OFF: begin
          if (pwdata[`SPE_CTRL_EN])
            en_q <= 1'b1;
          else if (pwdata[`SPE_CTRL_DIS] && master)
            en_q <= 1'b0; // Slave mode keeps running.
        end
        `SPE_MODE_OFF: mode_q <= pwdata; // Divide-select stored, unused.
        `SPE_MASK_OFF: mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // APB read data and answer: zero wait states, unmapped reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SPE_CTRL_OFF: prdata <= {31'h0, en_q};
          `SPE_MODE_OFF: prdata <= mode_q;
          `SPE_STAT_OFF: prdata <= {29'h0, stat_q};
          `SPE_MASK_OFF: prdata <= {29'h0, mask_q};
          `SPE_RXD_OFF:  prdata <= {24'h0, rx_hold_q};
          default:       prdata <= '0;
        endcase
      end
    end
  end

  // Slave receiver: shifts on the sampling edge of the synchronised clock.
  // Polarity changes while enabled look like an edge and can complete a char.
  logic sck_eff, samp_edge;
  assign sck_eff   = pins_s[2] ^ clock_polarity;
  assign samp_edge = sck_eff && !sck_prev_q;
  assign glitch    = en_q && !master && clock_polarity != pol_prev_q && bit_q == 3'd7;
  assign rx_load   = (en_q && !master && !pins_s[1] && samp_edge && bit_q == 3'd7) || glitch;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b0;
      pol_prev_q <= 1'b0;
      sh_q       <= '0;
      bit_q      <= '0;
      rx_hold_q  <= '0;
    end else begin
      sck_prev_q <= sck_eff;
      pol_prev_q <= clock_polarity;
      if (swrst || pins_s[1] || master) begin
        bit_q <= '0;
      end else if (en_q && samp_edge) begin
        sh_q  <= {sh_q[6:0], pins_s[0]};
        bit_q <= bit_q + 3'd1;
      end
      if (rx_load)
        rx_hold_q <= {sh_q[6:0], pins_s[0]};
    end
  end

  // Status: receive flag set on load (set wins over read), cleared by read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'b010;
    end else begin
      if (rx_load)
        stat_q[`SPE_ST_RXRDY] <= 1'b1;
      else if (rd && paddr == `SPE_RXD_OFF)
        stat_q[`SPE_ST_RXRDY] <= 1'b0;
      stat_q[`SPE_ST_TXEMPTY] <= st_q == SPE_IDLE; // No underrun bit exists.
      stat_q[`SPE_ST_ACTIVE]  <= en_q;
    end
  end

  // Level interrupt from unmasked receive flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q & 3'b001);
  end

  // Master clock generator; one byte per write of transmit data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= SPE_IDLE;
      cnt_q       <= '0;
      sck_q       <= 1'b0;
      sck_oe_q    <= 1'b0;
      mosi_q      <= 1'b0;
      cs_q        <= 2'b11;
      cs_sel_q    <= 1'b0;
      sh_q_m      <= '0;
      extra_q     <= 1'b0;
    end else begin
      sck_oe_q <= en_q && master;
      case (st_q)
        SPE_IDLE: begin
          sck_q <= clock_polarity;
          cs_q  <= 2'b11;
          if (en_q && master && wr && paddr == `SPE_TXD_OFF) begin
            cs_sel_q <= mode_q[`SPE_MODE_CS];
            sh_q_m   <= pwdata[7:0];
            mosi_q   <= pwdata[7];
            cs_q     <= mode_q[`SPE_MODE_CS] ? 2'b01 : 2'b10;
            cnt_q    <= 8'd0;
            // Dividers split between one and other values, idle-high clock, phase zero: stray pulse first.
            extra_q  <= clock_polarity && !clock_phase_select &&
                        ((mode_q[`SPE_MODE_DIV0 +: 8] == 8'd1) !=
                         (mode_q[`SPE_MODE_DIV1 +: 8] == 8'd1));
            st_q     <= SPE_LEAD;
          end
        end
        SPE_LEAD, SPE_TRAIL: begin
          if (cnt_q + 8'd1 >= div) begin
            cnt_q <= '0;
            sck_q <= !sck_q;
            if (extra_q) begin
              if (st_q == SPE_TRAIL)
                extra_q <= 1'b0;
              st_q <= st_q == SPE_LEAD ? SPE_TRAIL : SPE_LEAD;
            end else begin
              // Data moves only on a falling link clock edge, so a partner that
              // samples on rises sees it settled; the first bit is set at start.
              if (st_q == SPE_LEAD ? (clock_polarity && bit_m_q != 3'd0) : !clock_polarity) begin
                mosi_q <= sh_q_m[6];
                sh_q_m <= {sh_q_m[6:0], 1'b0};
              end
              if (st_q == SPE_LEAD)
                st_q <= SPE_TRAIL;
              else
                st_q <= bit_m_q == 3'd7 ? SPE_GAP : SPE_LEAD;
            end
          end else begin
            cnt_q <= cnt_q + 8'd1;
          end
        end
        default: begin
          st_q <= SPE_IDLE;
        end
      endcase
    end
  end

  // Master bit counter advances once per full clock period, except in the stray pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bit_m_q <= '0;
    else if (st_q == SPE_IDLE)
      bit_m_q <= '0;
    else if (st_q == SPE_TRAIL && !extra_q && cnt_q + 8'd1 >= div)
      bit_m_q <= bit_m_q + 3'd1;
  end

  assign link.sck_o  = sck_q;
  assign link.sck_oe = sck_oe_q;
  assign link.mosi   = mosi_q;
  assign link.cs_n   = cs_q;
endmodule

// ### verilog/spe_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
module spe_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
